// [pkg/bm_cmd_cfg.svh]
/*
 Constants for the bus-master command control block: register offsets,
 field positions, reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef BM_CMD_CFG_SVH
`define BM_CMD_CFG_SVH
// ============================================================
// Register map (byte offsets within the channel's I/O window)
`define BM_CMD_OFFSET 4'h0
`define BM_CMD_RESET 8'h00
// ============================================================
// Command field positions
`define BM_CMD_RUN_BIT 0
`define BM_CMD_DIR_BIT 3
`define BM_CMD_IMPL_MASK 8'h09
`define BM_CMD_RSVD_ZERO 8'h00
`endif

// [pkg/bm_cmd_pkg.sv]
/*
 Types for the bus-master command control block.
 Assumes bm_cmd_cfg.svh is on the include path.
*/
package bm_cmd_pkg;
`include "bm_cmd_cfg.svh"
  // ============================================================
  // Register read and write request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // ============================================================
  // Engine control handed to the data mover
  typedef struct packed {
    logic run;
    logic dir_write;
    logic start_pulse;
    logic abort_pulse;
    logic flush;
  } engine_ctrl_type;

  typedef enum logic [1:0] {
    IDLE,
    ACTIVE,
    DONE
  } op_state_type;
endpackage

// [rtl/edge_rise.sv]
/*
 Rising edge detector for a synchronous level.
 Assumes the input is already synchronous to core_clk.
*/
`timescale 1ns/1ps
module edge_rise (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Level in, pulse out
  input wire logic level,
  output logic pulse
);
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = level;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign pulse = level & ~prev_r;
endmodule // edge_rise

// [rtl/ide_bus_master_command_ctrl.sv]
/*
 Command control of one bus-master IDE channel: the 8-bit command
 register, run/direction control toward the data mover, the active and
 interrupt flags.
 Assumes a byte register port synchronous to core_clk, and a data mover
 that honours run, flush and reports the end-of-table region transfer.
*/
`timescale 1ns/1ps
`include "bm_cmd_cfg.svh"
// Functional notes
// - Bit 3 selects direction, 0 reads memory, 1 writes memory, reset 0.
// - Writing one to bit 0 enables bus-master operation.
// - Start only on a 0 to 1 change of bit 0, never on a rewrite of 1.
// - Data moves only while bit 0 is one.
// - Clearing bit 0 discards all transfer state so a later start is fresh.
// - Clearing bit 0 while active and drive unfinished is an abort.
// - Active sets on start and clears after the last region or on stop.
// - Interrupt sets on a rising drive interrupt, clears on a write of one.
module ide_bus_master_command_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire bm_cmd_pkg::reg_req_type req,
  output logic [7:0] rdata,
  // Status interface
  input wire logic irq_clear,
  output logic transfer_in_progress_flag,
  output logic irq_flag,
  // Data mover
  input wire logic last_region_marker,
  input wire logic last_region_done,
  input wire logic drive_done,
  input wire logic drive_irq,
  output bm_cmd_pkg::engine_ctrl_type ctrl
);
  // ============================================================
  // Command register
  logic run_r, run_nxt;
  logic dir_r, dir_nxt;
  logic cmd_wr;
  logic wr_run;
  // Named so its bits can be selected; a literal cannot be indexed
  localparam logic [7:0] cmd_reset_val = `BM_CMD_RESET;

  assign cmd_wr = req.wr && (req.addr == `BM_CMD_OFFSET);
  assign wr_run = req.wdata[`BM_CMD_RUN_BIT];

  always_comb begin
    run_nxt = run_r;
    dir_nxt = dir_r;
    if (cmd_wr) begin
      run_nxt = wr_run;
      // Only bits 3 and 0 are stored; others are dropped
      dir_nxt = req.wdata[`BM_CMD_DIR_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= cmd_reset_val[`BM_CMD_RUN_BIT];
      dir_r <= cmd_reset_val[`BM_CMD_DIR_BIT];
    end else begin
      run_r <= run_nxt;
      dir_r <= dir_nxt;
    end
  end

  // ============================================================
  // Start and stop edges
  logic start_evt;
  logic stop_evt;

  assign start_evt = cmd_wr && wr_run && !run_r;
  assign stop_evt = cmd_wr && !wr_run && run_r;

  // ============================================================
  // Operation state and active flag
  bm_cmd_pkg::op_state_type st_r, st_nxt;
  logic abort_nxt, abort_r;
  logic flush_nxt, flush_r;
  logic start_r;

  always_comb begin
    st_nxt = st_r;
    abort_nxt = 1'b0;
    flush_nxt = 1'b0;
    if (start_evt) begin
      st_nxt = bm_cmd_pkg::ACTIVE;
      flush_nxt = 1'b1; // Fresh start, no resume
    end else if (stop_evt) begin
      st_nxt = bm_cmd_pkg::IDLE;
      flush_nxt = 1'b1;
      abort_nxt = (st_r == bm_cmd_pkg::ACTIVE) && !drive_done;
    end else begin
      unique case (st_r)
        bm_cmd_pkg::IDLE: begin
        end
        bm_cmd_pkg::ACTIVE: begin
          if (last_region_done && last_region_marker) begin
            st_nxt = bm_cmd_pkg::DONE;
          end
        end
        bm_cmd_pkg::DONE: begin
        end
        default: begin
          st_nxt = bm_cmd_pkg::IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= bm_cmd_pkg::IDLE;
      abort_r <= 1'b0;
      flush_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      abort_r <= abort_nxt;
      flush_r <= flush_nxt;
      start_r <= start_evt;
    end
  end

  assign transfer_in_progress_flag = (st_r == bm_cmd_pkg::ACTIVE);

  // ============================================================
  // Interrupt flag; a new edge wins over a same-cycle clear
  logic irq_edge;
  logic irq_r, irq_nxt;

  edge_rise u_irq_edge (
    .core_clk(core_clk),
    .rstn(rstn),
    .level(drive_irq),
    .pulse(irq_edge)
  );

  always_comb begin
    irq_nxt = irq_r;
    if (irq_clear) begin
      irq_nxt = 1'b0;
    end
    if (irq_edge) begin
      irq_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign irq_flag = irq_r;

  // ============================================================
  // Mover control; run drops the same cycle stop is stored
  always_comb begin
    ctrl.run = run_r && (st_r == bm_cmd_pkg::ACTIVE);
    ctrl.dir_write = dir_r;
    ctrl.start_pulse = start_r;
    ctrl.abort_pulse = abort_r;
    ctrl.flush = flush_r;
  end

  // ============================================================
  // Read data; reserved positions forced to zero
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = `BM_CMD_RSVD_ZERO;
    if (req.rd && (req.addr == `BM_CMD_OFFSET)) begin
      rdata_nxt[`BM_CMD_RUN_BIT] = run_r;
      rdata_nxt[`BM_CMD_DIR_BIT] = dir_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `BM_CMD_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
endmodule // ide_bus_master_command_ctrl

// [testbench/ide_bus_master_command_ctrl_asserts.sv]
/* Port checker for the command block.
 Bound to the block; sees its ports only. */
`timescale 1ns/1ps
module cmd_checker (
  // Clock, reset and watched ports
  input wire logic core_clk,
  input wire logic rstn,
  input wire bm_cmd_pkg::reg_req_type req,
  input wire logic [7:0] rdata,
  input wire logic irq_clear,
  input wire logic transfer_in_progress_flag,
  input wire logic irq_flag,
  input wire logic last_region_marker,
  input wire logic last_region_done,
  input wire logic drive_done,
  input wire logic drive_irq,
  input wire bm_cmd_pkg::engine_ctrl_type ctrl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic w0;
  logic act;
  assign w0 = req.wr && req.addr == 4'h0;
  assign act = transfer_in_progress_flag;
  stop_halt_a: assert property (
    w0 && !req.wdata[0] |=> !act && !ctrl.run) else $error("no halt");
  abort_pulse_a: assert property (
    w0 && !req.wdata[0] |=>
    ctrl.abort_pulse == ($past(act) && !$past(drive_done)))
    else $error("abort");
  dir_follow_a: assert property (
    w0 |=> ctrl.dir_write == $past(req.wdata[3])) else $error("dir");
  run_act_a: assert property (ctrl.run |-> act) else $error("run");
  start_once_a: assert property (ctrl.start_pulse |-> ctrl.run ##1
    !ctrl.start_pulse) else $error("start");
  end_clear_a: assert property (act && last_region_done &&
    last_region_marker && !w0 |=> !act) else $error("end");
  mid_region_a: assert property (act && last_region_done &&
    !last_region_marker && !w0 |=> act) else $error("mid region");
  irq_set_a: assert property ($rose(drive_irq) |=> irq_flag)
    else $error("irq set");
  irq_hold_a: assert property (irq_flag && !irq_clear |=> irq_flag)
    else $error("irq hold");
  irq_clear_a: assert property (
    irq_clear && !$rose(drive_irq) |=> !irq_flag) else $error("irq clear");
  rsvd_zero_a: assert property ((rdata & 8'hF6) == 8'h00)
    else $error("reserved bits");
endmodule // cmd_checker

bind ide_bus_master_command_ctrl cmd_checker cmd_checker_i (.core_clk, .rstn,
  .req, .rdata, .irq_clear, .transfer_in_progress_flag, .irq_flag,
  .last_region_marker,
  .last_region_done, .drive_done, .drive_irq, .ctrl);

// [testbench/drive_model.sv]
/* Drive and memory side: finishes a started transfer after lat cycles
 of run. Assumes ctrl comes from the command block. */
`timescale 1ns/1ps
module drive_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control and latency
  input wire bm_cmd_pkg::engine_ctrl_type ctrl,
  input wire logic [31:0] lat,
  // Drive and mover status
  output logic last_region_marker,
  output logic last_region_done,
  output logic drive_done,
  output logic drive_irq
);
  int cnt;
  // A middle region ends with the marker low; only the last one has it
  assign last_region_marker = ctrl.run && cnt == 0;
  always @(posedge core_clk or negedge rstn) begin
    last_region_done <= 1'b0;
    if (!rstn) begin
      cnt <= 0;
      {drive_done, drive_irq} <= 2'h0;
    end else if (ctrl.flush) begin
      cnt <= ctrl.start_pulse ? lat : 0;
      {drive_done, drive_irq} <= 2'h0;
    end else if (ctrl.run && cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 3) last_region_done <= 1'b1;
      if (cnt == 1) {last_region_done, drive_done, drive_irq} <= 3'h7;
    end
  end
endmodule // drive_model

// [testbench/test_ide_bus_master_command_ctrl.sv]
/* Self-checking bench of the command block against a reference model.
 Assumes the package, drive model and checker are compiled first. */
`timescale 1ns/1ps
module test_ide_bus_master_command_ctrl;
  logic core_clk = 0, rstn = 0, irq_clear = 0;
  bm_cmd_pkg::reg_req_type req = '0;
  logic [7:0] rdata;
  logic transfer_in_progress_flag, irq_flag, last_region_marker;
  logic last_region_done, drive_done, drive_irq;
  bm_cmd_pkg::engine_ctrl_type ctrl;
  int lat = 3, mismatches = 0, total_checks = 0, cyc = 0, i;
  int m_run = 0, m_act = 0, m_dir = 0;
  ide_bus_master_command_ctrl ide_bus_master_command_ctrl_i (.core_clk,
    .rstn, .req, .rdata, .irq_clear, .transfer_in_progress_flag, .irq_flag,
    .last_region_marker, .last_region_done, .drive_done, .drive_irq, .ctrl);
  drive_model drive_model_i (.core_clk, .rstn, .ctrl, .lat,
    .last_region_marker, .last_region_done, .drive_done, .drive_irq);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 1000) begin
    mismatches++;
    conclude();
  end
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Idle cycle first, so no strobe is raised in the step it fell
  task wr(input logic [3:0] a, input logic [7:0] d);
    int st, ab;
    @(posedge core_clk) #2;
    st = a == 0 && d[0] && !m_run;
    ab = a == 0 && !d[0] && m_act && !drive_done;
    if (a == 0) begin
      m_act = d[0] ? m_act | st : 0;
      m_run = d[0];
      m_dir = d[3];
    end
    req.wr = 1;
    req.addr = a;
    req.wdata = d;
    @(posedge core_clk) #2 req.wr = 0;
    chk(ctrl.start_pulse, 8'(st));
    chk(ctrl.abort_pulse, 8'(ab));
    chk(transfer_in_progress_flag, 8'(m_act));
    chk(ctrl.run, 8'(m_act));
    chk(ctrl.dir_write, 8'(m_dir));
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk) #2 req.rd = 1;
    req.addr = a;
    @(posedge core_clk) #2 req.rd = 0;
    chk(rdata, e);
  endtask
  task finish_wait;
    for (i = 0; i < 60 && transfer_in_progress_flag === 1'b1; i++)
      @(posedge core_clk) #2;
    m_act = 0;
    chk(transfer_in_progress_flag, 8'h00);
    chk(irq_flag, 8'h01);
    irq_clear = 1;
    @(posedge core_clk) #2 irq_clear = 0;
    chk(irq_flag, 8'h00);
  endtask
  initial begin
    i = $urandom(74845);
    repeat (5) @(posedge core_clk);
    #2 rstn = 1;
    rd(4'h0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, 8'($urandom) & 8'hFE);
      rd(4'h0, 8'(m_dir << 3));
    end
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    wr(4'h0, 8'h09);
    wr(4'h0, 8'h09);
    finish_wait();
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    lat = 20;
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    chk(ctrl.flush, 8'h01);
    wr(4'h0, 8'h01);
    finish_wait();
    conclude();
  end
endmodule // test_ide_bus_master_command_ctrl
